// ===== design/pmff_pkg.sv
package pmff_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_MSG_CFG2    = 12'h622;
  localparam logic [11:0] ADDR_DOMAIN_VER  = 12'h624;
  localparam logic [11:0] ADDR_STATUS      = 12'h630;

  localparam logic [15:0] RST_MSG_CFG2     = 16'h0404;
  localparam logic [15:0] WMASK_MSG_CFG2   = 16'h1fb7;
  localparam logic [15:0] RST_DOMAIN_VER   = 16'h0200;
  localparam logic [15:0] WMASK_DOMAIN_VER = 16'h0fff;

  // ----------------------------------------------------------------------
  // Field positions of the configuration register
  // ----------------------------------------------------------------------
  localparam int BIT_UNICAST_EN  = 12;
  localparam int BIT_ALT_MASTER  = 11;
  localparam int BIT_ALL_HI_PRIO = 10;
  localparam int BIT_SYNC_ASSOC  = 9;
  localparam int BIT_DLY_ASSOC   = 8;
  localparam int BIT_PDLY_ASSOC  = 7;
  localparam int BIT_DOMAIN_EN   = 4;
  localparam int BIT_CSUM_REGEN  = 2;
  localparam int BIT_ANN_PORT1   = 1;
  localparam int BIT_ANN_PORT2   = 0;
  localparam int DOMAIN_MSB      = 7;

  // ----------------------------------------------------------------------
  // Ports, UDP ports and message types
  // ----------------------------------------------------------------------
  localparam logic [1:0]  PORT_LINE1 = 2'h1;
  localparam logic [1:0]  PORT_LINE2 = 2'h2;
  localparam logic [1:0]  PORT_HOST  = 2'h3;
  localparam logic [2:0]  FWD_LINE1  = 3'h1;
  localparam logic [2:0]  FWD_LINE2  = 3'h2;
  localparam logic [2:0]  FWD_HOST   = 3'h4;
  localparam logic [2:0]  FWD_NONE   = 3'h0;

  localparam logic [15:0] UDP_EVENT_PORT   = 16'h013f;
  localparam logic [15:0] UDP_GENERAL_PORT = 16'h0140;

  localparam logic [3:0] MT_SYNC        = 4'h0;
  localparam logic [3:0] MT_DELAY_REQ   = 4'h1;
  localparam logic [3:0] MT_PDELAY_REQ  = 4'h2;
  localparam logic [3:0] MT_PDELAY_RESP = 4'h3;
  localparam logic [3:0] MT_FOLLOW_UP   = 4'h8;
  localparam logic [3:0] MT_DELAY_RESP  = 4'h9;
  localparam logic [3:0] MT_PDELAY_RFU  = 4'ha;

  localparam int SRC_ID_W = 80;
  localparam int SEQ_W    = 16;

endpackage

// ===== design/pmff_assoc_slot.sv
`timescale 1ns/10ps
// ------------------------------------------------------------------------
// One remembered Sync or request identity and its comparison
// ------------------------------------------------------------------------
module pmff_assoc_slot (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_b,
  input  wire logic                            store,
  input  wire logic [7:0]                      st_domain,
  input  wire logic [pmff_pkg::SEQ_W-1:0]      st_seq,
  input  wire logic [pmff_pkg::SRC_ID_W-1:0]   st_src,
  input  wire logic [7:0]                      q_domain,
  input  wire logic [pmff_pkg::SEQ_W-1:0]      q_seq,
  input  wire logic [pmff_pkg::SRC_ID_W-1:0]   q_src,
  output logic                                 held,
  output logic                                 match
);
  import pmff_pkg::*;

  logic                  held_ff;
  logic [7:0]            domain_ff;
  logic [SEQ_W-1:0]      seq_ff;
  logic [SRC_ID_W-1:0]   src_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      held_ff   <= 1'b0;
      domain_ff <= 8'h00;
      seq_ff    <= '0;
      src_ff    <= '0;
    end else if (store) begin
      held_ff   <= 1'b1;
      domain_ff <= st_domain;
      seq_ff    <= st_seq;
      src_ff    <= st_src;
    end
  end

  // An empty slot never matches, so a stray response is never taken for a reply
  assign held  = held_ff;
  assign match = held_ff && (domain_ff == q_domain) && (seq_ff == q_seq) && (src_ff == q_src);

endmodule // pmff_assoc_slot

// ===== design/pmff_filter.sv
`timescale 1ns/10ps
// How it works
// - Unicast 319/320 frames follow table lookup
// - Unicast bit clear: only multicast is PTP
// - Alternate master: Sync, Follow_Up, Delay_Req/Resp from master cross line ports
// - No alternate master: Sync never crosses
// - No alternate master: Delay_Req host drop/cross
// - Priority queue: all PTP or events only
// - Follow_Up to host needs matching Sync
// - Delay_Resp matches Delay_Req: host else line
// - Pdelay responses to host need matching request
// - Domain check: match to host, else drop
// - Domain check off: default forwarding
// - IPv4 checksum regenerated or zeroed
// - Zero IPv4 checksum stays zero
// - IPv6 checksum always updated
// - Announce direction flags are host writable
// - Domain value from domain register low byte
module pmff_filter (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_b,
  input  wire logic [11:0]                     reg_addr,
  input  wire logic [15:0]                     reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic      [15:0]                     reg_rdata,
  input  wire logic                            desc_valid,
  input  wire logic [1:0]                      desc_port,
  input  wire logic                            desc_rsvd_addr,
  input  wire logic                            desc_is_udp,
  input  wire logic                            desc_is_ipv6,
  input  wire logic [15:0]                     desc_udp_dport,
  input  wire logic [3:0]                      desc_msg_type,
  input  wire logic [7:0]                      desc_domain,
  input  wire logic [pmff_pkg::SEQ_W-1:0]      desc_seq,
  input  wire logic [pmff_pkg::SRC_ID_W-1:0]   desc_src,
  input  wire logic [2:0]                      desc_lookup,
  input  wire logic                            desc_modified,
  input  wire logic [15:0]                     desc_csum_in,
  input  wire logic [15:0]                     desc_csum_calc,
  output logic                                 dec_valid,
  output logic      [2:0]                      dec_fwd,
  output logic                                 dec_is_ptp,
  output logic                                 dec_hi_prio,
  output logic                                 dec_csum_wr,
  output logic      [15:0]                     dec_csum
);
  import pmff_pkg::*;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0] cfg_ff;
  logic [15:0] dom_ver_ff;
  logic [7:0]  drop_cnt_ff;
  logic [15:0] rdata_ff;
  logic [2:0]  held;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ff <= RST_MSG_CFG2;
    end else if (reg_wr && reg_addr == ADDR_MSG_CFG2) begin
      cfg_ff <= (reg_wdata & WMASK_MSG_CFG2) | (cfg_ff & ~WMASK_MSG_CFG2);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dom_ver_ff <= RST_DOMAIN_VER;
    end else if (reg_wr && reg_addr == ADDR_DOMAIN_VER) begin
      dom_ver_ff <= (reg_wdata & WMASK_DOMAIN_VER) | (dom_ver_ff & ~WMASK_DOMAIN_VER);
    end
  end

  // Unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_MSG_CFG2:   rdata_ff <= cfg_ff;
        ADDR_DOMAIN_VER: rdata_ff <= dom_ver_ff;
        ADDR_STATUS:     rdata_ff <= {drop_cnt_ff, 5'h00, held};
        default:         rdata_ff <= 16'h0000;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end
  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------------
  // Frame classification
  // ----------------------------------------------------------------------
  logic       from_line;
  logic       from_master;
  logic       same_dom;
  logic       udp_ptp_port;
  logic       mcast_ptp;
  logic       ucast_ptp;
  logic       is_event;
  logic [2:0] other_line;
  logic [7:0] cfg_domain;

  assign cfg_domain   = dom_ver_ff[DOMAIN_MSB:0];
  assign from_line    = (desc_port == PORT_LINE1) || (desc_port == PORT_LINE2);
  assign other_line   = (desc_port == PORT_LINE1) ? FWD_LINE2 : FWD_LINE1;
  // An active master is taken to be the port whose Announce direction flag is set
  assign from_master  = (desc_port == PORT_LINE1 && cfg_ff[BIT_ANN_PORT1]) ||
                        (desc_port == PORT_LINE2 && cfg_ff[BIT_ANN_PORT2]);
  assign same_dom     = (desc_domain == cfg_domain);
  assign udp_ptp_port = desc_is_udp && (desc_udp_dport == UDP_EVENT_PORT || desc_udp_dport == UDP_GENERAL_PORT);
  assign mcast_ptp    = desc_rsvd_addr;
  assign ucast_ptp    = !desc_rsvd_addr && udp_ptp_port && cfg_ff[BIT_UNICAST_EN];

  always_comb begin
    case (desc_msg_type)
      MT_SYNC, MT_DELAY_REQ, MT_PDELAY_REQ, MT_PDELAY_RESP: is_event = 1'b1;
      default:                                             is_event = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Association slots: Sync seen toward host, requests sent by host
  // ----------------------------------------------------------------------
  logic       st_sync;
  logic       st_dreq;
  logic       st_preq;
  logic [2:0] hit;
  logic [2:0] st_vec;

  assign st_sync = desc_valid && mcast_ptp && from_line && desc_msg_type == MT_SYNC;
  assign st_dreq = desc_valid && mcast_ptp && desc_port == PORT_HOST && desc_msg_type == MT_DELAY_REQ;
  assign st_preq = desc_valid && mcast_ptp && desc_port == PORT_HOST && desc_msg_type == MT_PDELAY_REQ;
  assign st_vec  = {st_preq, st_dreq, st_sync};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_slot
      pmff_assoc_slot u_slot (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .store     (st_vec[gi]),
        .st_domain (desc_domain),
        .st_seq    (desc_seq),
        .st_src    (desc_src),
        .q_domain  (desc_domain),
        .q_seq     (desc_seq),
        .q_src     (desc_src),
        .held      (held[gi]),
        .match     (hit[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Forwarding decision
  // ----------------------------------------------------------------------
  logic [2:0] nxt_fwd;

  always_comb begin
    nxt_fwd = desc_lookup;
    if (mcast_ptp) begin
      if (!from_line) begin
        nxt_fwd = desc_lookup & (FWD_LINE1 | FWD_LINE2);
      end else begin
        nxt_fwd = FWD_HOST;
        case (desc_msg_type)
          MT_SYNC: begin
            if (cfg_ff[BIT_ALT_MASTER] && same_dom && from_master) begin
              nxt_fwd = nxt_fwd | other_line;
            end  // otherwise Sync stays off the other line port
          end
          MT_FOLLOW_UP: begin
            if (cfg_ff[BIT_ALT_MASTER] && same_dom && from_master) begin
              nxt_fwd = nxt_fwd | other_line;
            end
            if (cfg_ff[BIT_SYNC_ASSOC] && !hit[0]) begin
              nxt_fwd = nxt_fwd & ~FWD_HOST;
            end
          end
          MT_DELAY_REQ: begin
            if (cfg_ff[BIT_ALT_MASTER]) begin
              if (same_dom && from_master) begin
                nxt_fwd = nxt_fwd | other_line;
              end
            end else if (same_dom && from_master) begin
              nxt_fwd = FWD_NONE;
            end else if (!same_dom) begin
              nxt_fwd = other_line;
            end
          end
          MT_DELAY_RESP: begin
            if (cfg_ff[BIT_ALT_MASTER] && same_dom && from_master) begin
              nxt_fwd = nxt_fwd | other_line;
            end
            if (cfg_ff[BIT_DLY_ASSOC]) begin
              nxt_fwd = hit[1] ? FWD_HOST : other_line;
            end
          end
          MT_PDELAY_RESP, MT_PDELAY_RFU: begin
            if (cfg_ff[BIT_PDLY_ASSOC] && !hit[2]) begin
              nxt_fwd = nxt_fwd & ~FWD_HOST;
            end
          end
          default: begin
            nxt_fwd = FWD_HOST;
          end
        endcase
        if (cfg_ff[BIT_DOMAIN_EN] && !same_dom) begin
          nxt_fwd = FWD_NONE;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checksum of egress UDP frames
  // ----------------------------------------------------------------------
  logic        nxt_csum_wr;
  logic [15:0] nxt_csum;

  always_comb begin
    nxt_csum_wr = 1'b0;
    nxt_csum    = 16'h0000;
    if (desc_is_udp && desc_modified) begin
      nxt_csum_wr = 1'b1;
      if (desc_is_ipv6) begin
        nxt_csum = desc_csum_calc;
      end else if (desc_csum_in == 16'h0000) begin
        nxt_csum = 16'h0000;
      end else if (cfg_ff[BIT_CSUM_REGEN]) begin
        nxt_csum = desc_csum_calc;
      end else begin
        nxt_csum = 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered decision, one cycle after the descriptor
  // ----------------------------------------------------------------------
  logic        dec_valid_ff;
  logic [2:0]  dec_fwd_ff;
  logic        dec_ptp_ff;
  logic        dec_prio_ff;
  logic        dec_csum_wr_ff;
  logic [15:0] dec_csum_ff;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dec_valid_ff   <= 1'b0;
      dec_fwd_ff     <= FWD_NONE;
      dec_ptp_ff     <= 1'b0;
      dec_prio_ff    <= 1'b0;
      dec_csum_wr_ff <= 1'b0;
      dec_csum_ff    <= 16'h0000;
    end else begin
      dec_valid_ff   <= desc_valid;
      dec_fwd_ff     <= desc_valid ? nxt_fwd : FWD_NONE;
      dec_ptp_ff     <= desc_valid && (mcast_ptp || ucast_ptp);
      dec_prio_ff    <= desc_valid && (mcast_ptp || ucast_ptp) &&
                        (cfg_ff[BIT_ALL_HI_PRIO] || is_event);
      dec_csum_wr_ff <= desc_valid && nxt_csum_wr;
      dec_csum_ff    <= desc_valid ? nxt_csum : 16'h0000;
    end
  end

  // Saturates so a flood of drops cannot wrap back to a small value
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      drop_cnt_ff <= 8'h00;
    end else if (desc_valid && mcast_ptp && nxt_fwd == FWD_NONE && drop_cnt_ff != 8'hff) begin
      drop_cnt_ff <= drop_cnt_ff + 8'h01;
    end
  end

  assign dec_valid   = dec_valid_ff;
  assign dec_fwd     = dec_fwd_ff;
  assign dec_is_ptp  = dec_ptp_ff;
  assign dec_hi_prio = dec_prio_ff;
  assign dec_csum_wr = dec_csum_wr_ff;
  assign dec_csum    = dec_csum_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  chk_unicast_lookup: assert property (
    desc_valid && ucast_ptp |=> dec_is_ptp && dec_fwd == $past(desc_lookup))
    else $error("unicast PTP frame not forwarded by lookup");
  chk_mcast_only: assert property (
    desc_valid && !desc_rsvd_addr && !cfg_ff[BIT_UNICAST_EN] |=> !dec_is_ptp)
    else $error("unicast frame taken as PTP while disabled");
  chk_alt_sync_cross: assert property (
    desc_valid && mcast_ptp && desc_port == PORT_LINE1 && desc_msg_type == MT_SYNC && same_dom &&
    cfg_ff[BIT_ALT_MASTER] && cfg_ff[BIT_ANN_PORT1] && !cfg_ff[BIT_DOMAIN_EN] |=> dec_fwd[1])
    else $error("master Sync not crossed with alternate master");
  chk_sync_no_cross: assert property (
    desc_valid && mcast_ptp && desc_port == PORT_LINE2 && desc_msg_type == MT_SYNC &&
    !cfg_ff[BIT_ALT_MASTER] |=> !dec_fwd[0])
    else $error("Sync crossed line ports without alternate master");
  chk_dreq_discard: assert property (
    desc_valid && mcast_ptp && from_line && desc_msg_type == MT_DELAY_REQ && !cfg_ff[BIT_ALT_MASTER] &&
    same_dom && from_master |=> dec_fwd == FWD_NONE)
    else $error("master Delay_Req not discarded");
  chk_prio_queue: assert property (
    desc_valid && mcast_ptp |=> dec_hi_prio == ($past(cfg_ff[BIT_ALL_HI_PRIO]) || $past(is_event)))
    else $error("PTP queue selection wrong");
  chk_dresp_match: assert property (
    desc_valid && mcast_ptp && from_line && desc_msg_type == MT_DELAY_RESP && cfg_ff[BIT_DLY_ASSOC] &&
    !cfg_ff[BIT_DOMAIN_EN] |=> dec_fwd[2] == $past(hit[1]))
    else $error("Delay_Resp association routing wrong");
  chk_domain_drop: assert property (
    desc_valid && mcast_ptp && from_line && cfg_ff[BIT_DOMAIN_EN] && !same_dom |=> dec_fwd == FWD_NONE)
    else $error("domain mismatch not dropped");
  chk_csum_zero_kept: assert property (
    desc_valid && desc_is_udp && !desc_is_ipv6 && desc_csum_in == 16'h0000 |=> dec_csum == 16'h0000)
    else $error("zero IPv4 checksum changed");
  chk_csum_ipv6: assert property (
    desc_valid && desc_is_udp && desc_is_ipv6 && desc_modified |=>
    dec_csum_wr && dec_csum == $past(desc_csum_calc))
    else $error("IPv6 checksum not updated");
  chk_ann_flags: assert property (
    reg_wr && reg_addr == ADDR_MSG_CFG2 ##1 !reg_wr ##1 reg_rd && reg_addr == ADDR_MSG_CFG2 |=>
    reg_rdata[1:0] == $past(reg_wdata[1:0], 3))
    else $error("Announce flags not written");

  cov_alt_master: cover property (desc_valid && mcast_ptp && cfg_ff[BIT_ALT_MASTER] && from_master);
  cov_dresp_hit: cover property (desc_valid && desc_msg_type == MT_DELAY_RESP && hit[1]);
  cov_domain_drop: cover property (desc_valid && mcast_ptp && cfg_ff[BIT_DOMAIN_EN] && !same_dom);
  cov_unicast: cover property (desc_valid && ucast_ptp);

endmodule // pmff_filter

// ===== testbench/pmff_frame_src.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Frame descriptor source standing in for the switch ports
// ----------------------------------------------------------------------
module pmff_frame_src (
  input  wire logic                          ref_clk,
  output logic                               desc_valid,
  output logic [1:0]                         desc_port,
  output logic                               desc_rsvd_addr,
  output logic                               desc_is_udp,
  output logic                               desc_is_ipv6,
  output logic [15:0]                        desc_udp_dport,
  output logic [3:0]                         desc_msg_type,
  output logic [7:0]                         desc_domain,
  output logic [pmff_pkg::SEQ_W-1:0]         desc_seq,
  output logic [pmff_pkg::SRC_ID_W-1:0]      desc_src,
  output logic [2:0]                         desc_lookup,
  output logic                               desc_modified,
  output logic [15:0]                        desc_csum_in,
  output logic [15:0]                        desc_csum_calc
);
  import pmff_pkg::*;
  logic        u_udp, u_v6, u_mod;
  logic [15:0] u_dport, u_cin, u_calc;

  initial begin
    {desc_valid, desc_port, desc_rsvd_addr, desc_is_udp, desc_is_ipv6} = '0;
    {desc_udp_dport, desc_msg_type, desc_domain, desc_seq} = '0;
    {desc_lookup, desc_modified, desc_csum_in, desc_csum_calc} = '0;
    desc_src = {5{16'h5a3c}};
    {u_udp, u_v6, u_mod, u_dport, u_cin, u_calc} = '0;
  end

  task automatic set_udp(input logic udp, input logic v6, input logic [15:0] dp,
                         input logic md, input logic [15:0] ci, input logic [15:0] ca);
    {u_udp, u_v6, u_dport, u_mod, u_cin, u_calc} = {udp, v6, dp, md, ci, ca};
  endtask

  task automatic send(input logic [1:0] p, input logic r, input logic [3:0] mt,
                      input logic [7:0] d, input logic [15:0] s);
    @(posedge ref_clk);
    desc_valid     <= 1'b1;
    desc_port      <= p;
    desc_rsvd_addr <= r;
    desc_msg_type  <= mt;
    desc_domain    <= d;
    desc_seq       <= s;
    desc_lookup    <= 3'h5;
    {desc_is_udp, desc_is_ipv6, desc_udp_dport} <= {u_udp, u_v6, u_dport};
    {desc_modified, desc_csum_in, desc_csum_calc} <= {u_mod, u_cin, u_calc};
    @(posedge ref_clk);
    // Domain, sequence, type and checksum fields lose their value after the frame so stale data never matches
    desc_valid     <= 1'b0;
    desc_domain    <= ~d;
    desc_seq       <= ~s;
    desc_msg_type  <= ~mt;
    desc_csum_in   <= ~u_cin;
    desc_csum_calc <= ~u_calc;
  endtask
endmodule // pmff_frame_src

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import pmff_pkg::*;
  logic ref_clk, rst_b, reg_wr, reg_rd, dec_valid, dec_is_ptp, dec_hi_prio, dec_csum_wr;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, dec_csum;
  logic [2:0]  dec_fwd;
  logic d_v, d_r, d_u, d_6, d_m;
  logic [1:0] d_p;
  logic [15:0] d_dp, d_ci, d_ca, d_s;
  logic [3:0] d_mt;
  logic [7:0] d_d;
  logic [SRC_ID_W-1:0] d_src;
  logic [2:0] d_lk;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [3:0] types [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha};

  pmff_frame_src u_src (.ref_clk(ref_clk), .desc_valid(d_v), .desc_port(d_p), .desc_rsvd_addr(d_r),
    .desc_is_udp(d_u), .desc_is_ipv6(d_6), .desc_udp_dport(d_dp), .desc_msg_type(d_mt),
    .desc_domain(d_d), .desc_seq(d_s), .desc_src(d_src), .desc_lookup(d_lk), .desc_modified(d_m),
    .desc_csum_in(d_ci), .desc_csum_calc(d_ca));

  pmff_filter DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .desc_valid(d_v), .desc_port(d_p),
    .desc_rsvd_addr(d_r), .desc_is_udp(d_u), .desc_is_ipv6(d_6), .desc_udp_dport(d_dp),
    .desc_msg_type(d_mt), .desc_domain(d_d), .desc_seq(d_s), .desc_src(d_src), .desc_lookup(d_lk),
    .desc_modified(d_m), .desc_csum_in(d_ci), .desc_csum_calc(d_ca), .dec_valid(dec_valid),
    .dec_fwd(dec_fwd), .dec_is_ptp(dec_is_ptp), .dec_hi_prio(dec_hi_prio),
    .dec_csum_wr(dec_csum_wr), .dec_csum(dec_csum));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    cmp(reg_rdata, exp);
  endtask

  task automatic frame(input logic [1:0] p, input logic r, input logic [3:0] mt, input logic [7:0] d,
                       input logic [15:0] s, input logic [2:0] f, input logic ptp, input logic pri);
    u_src.send(p, r, mt, d, s);
    #1;
    cmp({15'h0, dec_valid}, 16'h0001);
    cmp({13'h0, dec_fwd}, {13'h0, f});
    cmp({14'h0, dec_is_ptp, dec_hi_prio}, {14'h0, ptp, pri});
  endtask

  task automatic csum(input logic w, input logic [15:0] v);
    cmp({15'h0, dec_csum_wr}, {15'h0, w});
    cmp(dec_csum, v);
  endtask

  // Hang guard: the bus never stalls, so a long run means a stuck sequence
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    results();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(ADDR_MSG_CFG2, 16'h0404);
    rd(ADDR_DOMAIN_VER, 16'h0200);
    rd(12'h700, 16'h0000);
    wr(ADDR_MSG_CFG2, 16'hffff);
    rd(ADDR_MSG_CFG2, 16'h1fb7);
    wr(ADDR_DOMAIN_VER, 16'hffff);
    rd(ADDR_DOMAIN_VER, 16'h0fff);
    wr(ADDR_DOMAIN_VER, 16'h0005);
    wr(12'h700, 16'h1234);
    rd(ADDR_MSG_CFG2, 16'h1fb7);
    // Unicast recognition off then on, and event classes on the unicast path
    u_src.set_udp(1'b1, 1'b0, UDP_EVENT_PORT, 1'b0, 16'h0000, 16'h0000);
    wr(ADDR_MSG_CFG2, 16'h0000);
    frame(PORT_LINE1, 1'b0, MT_SYNC, 8'h05, 16'h0001, 3'h5, 1'b0, 1'b0);
    wr(ADDR_MSG_CFG2, 16'h1000);
    foreach (types[i]) begin
      frame(PORT_LINE2, 1'b0, types[i], 8'h05, 16'h0001, 3'h5, 1'b1, types[i] < 4'h4);
    end
    wr(ADDR_MSG_CFG2, 16'h1400);
    frame(PORT_LINE2, 1'b0, MT_FOLLOW_UP, 8'h05, 16'h0001, 3'h5, 1'b1, 1'b1);
    // Port 1 is the active master from here on
    wr(ADDR_MSG_CFG2, 16'h0002);
    frame(PORT_LINE1, 1'b1, MT_SYNC, 8'h05, 16'h0002, 3'h4, 1'b1, 1'b1);
    frame(PORT_LINE2, 1'b1, MT_SYNC, 8'h05, 16'h0002, 3'h4, 1'b1, 1'b1);
    wr(ADDR_MSG_CFG2, 16'h0802);
    frame(PORT_LINE1, 1'b1, MT_SYNC, 8'h05, 16'h0003, 3'h6, 1'b1, 1'b1);
    wr(ADDR_MSG_CFG2, 16'h0002);
    frame(PORT_LINE1, 1'b1, MT_DELAY_REQ, 8'h05, 16'h0004, 3'h0, 1'b1, 1'b1);
    frame(PORT_LINE1, 1'b1, MT_DELAY_REQ, 8'h09, 16'h0004, 3'h2, 1'b1, 1'b1);
    // Request from the host is stored, then a matching and a stale response
    wr(ADDR_MSG_CFG2, 16'h0102);
    frame(PORT_HOST, 1'b1, MT_DELAY_REQ, 8'h05, 16'h0007, 3'h1, 1'b1, 1'b1);
    frame(PORT_LINE1, 1'b1, MT_DELAY_RESP, 8'h05, 16'h0007, 3'h4, 1'b1, 1'b0);
    frame(PORT_LINE1, 1'b1, MT_DELAY_RESP, 8'h05, 16'h0008, 3'h2, 1'b1, 1'b0);
    wr(ADDR_MSG_CFG2, 16'h0012);
    frame(PORT_LINE1, 1'b1, MT_SYNC, 8'h06, 16'h0009, 3'h0, 1'b1, 1'b1);
    frame(PORT_LINE1, 1'b1, MT_SYNC, 8'h05, 16'h000a, 3'h4, 1'b1, 1'b1);
    // Checksum handling of modified egress frames
    wr(ADDR_MSG_CFG2, 16'h0006);
    u_src.set_udp(1'b1, 1'b0, UDP_EVENT_PORT, 1'b1, 16'h1234, 16'habcd);
    frame(PORT_LINE1, 1'b1, MT_SYNC, 8'h05, 16'h000b, 3'h4, 1'b1, 1'b1);
    csum(1'b1, 16'habcd);
    u_src.set_udp(1'b1, 1'b0, UDP_EVENT_PORT, 1'b1, 16'h0000, 16'habcd);
    frame(PORT_LINE1, 1'b1, MT_SYNC, 8'h05, 16'h000c, 3'h4, 1'b1, 1'b1);
    csum(1'b1, 16'h0000);
    wr(ADDR_MSG_CFG2, 16'h0002);
    u_src.set_udp(1'b1, 1'b0, UDP_EVENT_PORT, 1'b1, 16'h1234, 16'habcd);
    frame(PORT_LINE1, 1'b1, MT_SYNC, 8'h05, 16'h000d, 3'h4, 1'b1, 1'b1);
    csum(1'b1, 16'h0000);
    u_src.set_udp(1'b1, 1'b1, UDP_EVENT_PORT, 1'b1, 16'h1234, 16'habcd);
    frame(PORT_LINE1, 1'b1, MT_SYNC, 8'h05, 16'h000e, 3'h4, 1'b1, 1'b1);
    csum(1'b1, 16'habcd);
    // Follow_Up reaches the host only when it pairs with the last Sync
    wr(ADDR_MSG_CFG2, 16'h0202);
    frame(PORT_LINE1, 1'b1, MT_FOLLOW_UP, 8'h05, 16'h000e, 3'h4, 1'b1, 1'b0);
    frame(PORT_LINE1, 1'b1, MT_FOLLOW_UP, 8'h05, 16'h000f, 3'h0, 1'b1, 1'b0);
    // Peer delay responses reach the host only against the host's request
    wr(ADDR_MSG_CFG2, 16'h0082);
    frame(PORT_HOST, 1'b1, MT_PDELAY_REQ, 8'h05, 16'h0010, 3'h1, 1'b1, 1'b1);
    frame(PORT_LINE2, 1'b1, MT_PDELAY_RESP, 8'h05, 16'h0010, 3'h4, 1'b1, 1'b1);
    frame(PORT_LINE2, 1'b1, MT_PDELAY_RFU, 8'h05, 16'h0011, 3'h0, 1'b1, 1'b0);
    // Four drops so far, the Sync slot and both request slots held
    rd(ADDR_STATUS, 16'h0407);
    results();
  end
endmodule // tb_top
